// ### shared/tci_pkg.sv
// Constants, types and behaviour notes for the three-channel interval timer
// Notes on behaviour
// - Mode 1: output idles high, low after gate rise, high at terminal count.
// - Mode 1: count written during pulse applies only from next trigger.
// - Mode 1: each gate rise restarts the full count.
// - Count may be read any time without disturbing the pulse.
// - Mode 2: one-clock low pulse, period equals loaded count.
// - Mode 2: reload between pulses takes effect next period.
// - Mode 2: gate low holds output high; gate rise restarts count.
// - Mode 2: output stays high until a count is written.
// - Mode 3: decrement by two per clock fall; toggle and reload at terminal.
// - Mode 3 odd count: first step minus 1 high, minus 3 low.
// - Mode 4: counting starts on write; one-clock low pulse at terminal.
// - Mode 4: rewritten count loads on the next counter clock.
// - Mode 4: gate low suspends decrementing.
// - Mode 5: gate rise starts count, one-clock low pulse, retriggerable.
// - Control word only affects the counter its select field names.
// - Data access: low only, high only, or low then high.
// - Read-back with count latch low latches every masked counter.
// - Read-back with status latch low latches status, read via data register.
// - Access type 00 latches count into hold register without disturbing count.
// - Select all ones with count latch low latches several counters.
// - Control word: select 7:6, access 5:4, mode 3:1, decimal bit 0.
// - Mode decode 000,001,x10,x11,100,101; binary or decimal 0..9999 counting.
// - Read-back: bit 5 count latch_n, bit 4 status latch_n, 3:1 mask.
// - Status byte: output bit 7, null count bit 6, 5:0 programming echo.
package tci_pkg;
  localparam logic [7:0] TCI_OFS_CNT0 = 8'h18;
  localparam logic [7:0] TCI_OFS_CNT1 = 8'h19;
  localparam logic [7:0] TCI_OFS_CNT2 = 8'h1a;
  localparam logic [7:0] TCI_OFS_CTRL = 8'h1b;
  localparam int TCI_NUM = 3;
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_ACC_HI = 5;
  localparam int CW_ACC_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD = 0;
  localparam int RB_CNT_N = 5;
  localparam int RB_STA_N = 4;
  localparam int RB_MASK_LO = 1;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LO = 2'h1;
  localparam logic [1:0] ACC_HI = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;
  localparam logic [15:0] TCI_CNT_RST = 16'h0000;
  localparam logic [2:0] TCI_MODE_RST = 3'h0;
  localparam logic [1:0] TCI_ACC_RST = 2'h3;
  localparam logic TCI_OUT_RST = 1'b1;
  localparam logic [7:0] TCI_RD_IDLE = 8'h00;

  typedef enum logic [2:0] {TCI_M0, TCI_M1, TCI_M2, TCI_M3, TCI_M4, TCI_M5} tci_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tci_bus_req_s;

  // Bit 2 is a don't-care for modes 2 and 3
  function automatic tci_mode_e tci_mode_decode(input logic [2:0] m);
    tci_mode_e r;
    case (m)
      3'h0: r = TCI_M0;
      3'h1: r = TCI_M1;
      3'h4: r = TCI_M4;
      3'h5: r = TCI_M5;
      default: r = m[0] ? TCI_M3 : TCI_M2;
    endcase
    return r;
  endfunction
endpackage

// ### core/tci_timer.sv
// Three-channel 16-bit interval timer with byte-wide host register port
`timescale 1ns/10ps
module tci_timer
  import tci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire tci_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  output wire logic [2:0] cnt_out
);

  // Decimal-aware decrement by one, wrapping 0 to 9999 or 65535
  function automatic logic [15:0] tci_dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic b;
    r = v;
    b = 1'b1;
    for (int d = 0; d < 4; d++)
    begin
      if (b)
      begin
        if (r[4*d +: 4] == 4'h0)
          r[4*d +: 4] = 4'h9;
        else
        begin
          r[4*d +: 4] = r[4*d +: 4] - 4'h1;
          b = 1'b0;
        end
      end
    end
    return bcd ? r : v - 16'h0001;
  endfunction

  // Decrement by up to three steps, used by the square wave mode
  function automatic logic [15:0] tci_decn(input logic [15:0] v, input logic [1:0] n,
                                           input logic bcd);
    logic [15:0] r;
    r = v;
    for (int k = 0; k < 3; k++)
    begin
      if (2'(k) < n)
        r = tci_dec1(r, bcd);
    end
    return r;
  endfunction

  logic [7:0] rd_byte [TCI_NUM];
  logic cw_wr;
  logic [1:0] cw_sel;
  logic [1:0] cw_acc;
  logic rd_hit_any;
  logic [1:0] rd_idx;

  // Shared control word decode
  assign cw_wr = bus_req.wr && (bus_req.addr == TCI_OFS_CTRL);
  assign cw_sel = bus_req.wdata[CW_SEL_HI:CW_SEL_LO];
  assign cw_acc = bus_req.wdata[CW_ACC_HI:CW_ACC_LO];

  // Data register address decode for reads
  always_comb
  begin
    rd_hit_any = 1'b0;
    rd_idx = 2'h0;
    case (bus_req.addr)
      TCI_OFS_CNT0:
      begin
        rd_hit_any = 1'b1;
        rd_idx = 2'h0;
      end
      TCI_OFS_CNT1:
      begin
        rd_hit_any = 1'b1;
        rd_idx = 2'h1;
      end
      TCI_OFS_CNT2:
      begin
        rd_hit_any = 1'b1;
        rd_idx = 2'h2;
      end
      default:
      begin
        rd_hit_any = 1'b0;
        rd_idx = 2'h0;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      bus_rdata <= TCI_RD_IDLE;
    else if (bus_req.rd && rd_hit_any)
      bus_rdata <= rd_byte[rd_idx];
    else
      bus_rdata <= TCI_RD_IDLE;
  end

  for (genvar i = 0; i < TCI_NUM; i++)
  begin : g_ch
    logic [15:0] cnt_reg;
    logic [15:0] init_reg;
    logic [15:0] hold_reg;
    logic [7:0] stat_reg;
    logic [2:0] mode_reg;
    logic [1:0] acc_reg;
    logic bcd_reg;
    logic wphase_reg;
    logic rphase_reg;
    logic out_reg;
    logic null_reg;
    logic have_reg;
    logic armed_reg;
    logic pend_reg;
    logic trig_reg;
    logic hold_vld_reg;
    logic stat_vld_reg;
    logic gprev_reg;
    logic cprev_reg;
    logic [7:0] ofs;
    logic dw;
    logic commit;
    logic cw_this;
    logic rb_this;
    logic cw_prog;
    logic cw_latch;
    logic cw_stat;
    logic rd_hit;
    logic cfall;
    logic grise;
    logic tg;
    logic [1:0] amt;
    logic [15:0] src;
    tci_mode_e md;

    assign ofs = TCI_OFS_CNT0 + 8'(i);
    assign dw = bus_req.wr && (bus_req.addr == ofs);
    assign rd_hit = bus_req.rd && (bus_req.addr == ofs);
    // Paired access commits only on the high byte
    assign commit = dw && ((acc_reg != ACC_BOTH) || wphase_reg);
    assign cw_this = cw_wr && (cw_sel == 2'(i));
    assign rb_this = cw_wr && (cw_sel == SEL_READBACK) && bus_req.wdata[RB_MASK_LO + i];
    assign cw_prog = cw_this && (cw_acc != ACC_LATCH);
    assign cw_latch = (cw_this && (cw_acc == ACC_LATCH))
                      || (rb_this && !bus_req.wdata[RB_CNT_N]);
    assign cw_stat = rb_this && !bus_req.wdata[RB_STA_N];
    assign md = tci_mode_decode(mode_reg);
    // Counter clock acts on its falling edge
    assign cfall = cprev_reg && !cnt_clk[i];
    assign grise = !gprev_reg && cnt_gate[i];
    // A gate rise seen in the same cycle as the clock fall still counts
    assign tg = trig_reg || grise;
    // Odd counts take 1 while high and 3 while low
    assign amt = cnt_reg[0] ? (out_reg ? 2'h1 : 2'h3) : 2'h2;
    assign cnt_out[i] = out_reg;

    // Programming: mode, access type, number base, initial count
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        mode_reg <= TCI_MODE_RST;
        acc_reg <= TCI_ACC_RST;
        bcd_reg <= 1'b0;
        init_reg <= TCI_CNT_RST;
        wphase_reg <= 1'b0;
      end
      else if (cw_prog)
      begin
        mode_reg <= bus_req.wdata[CW_MODE_HI:CW_MODE_LO];
        acc_reg <= cw_acc;
        bcd_reg <= bus_req.wdata[CW_BCD];
        wphase_reg <= 1'b0;
      end
      else if (dw)
      begin
        case (acc_reg)
          ACC_LO: init_reg <= {8'h00, bus_req.wdata};
          ACC_HI: init_reg <= {bus_req.wdata, 8'h00};
          default:
          begin
            if (wphase_reg)
              init_reg[15:8] <= bus_req.wdata;
            else
              init_reg[7:0] <= bus_req.wdata;
            wphase_reg <= !wphase_reg;
          end
        endcase
      end
    end

    // Counting element and output, stepped on each counter clock fall
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        cnt_reg <= TCI_CNT_RST;
        out_reg <= TCI_OUT_RST;
        null_reg <= 1'b0;
        have_reg <= 1'b0;
        armed_reg <= 1'b0;
        pend_reg <= 1'b0;
        trig_reg <= 1'b0;
        gprev_reg <= 1'b1;
        cprev_reg <= 1'b0;
      end
      else
      begin
        cprev_reg <= cnt_clk[i];
        gprev_reg <= cnt_gate[i];
        if (cw_prog)
        begin
          // New mode: output to its idle level, wait for a count
          out_reg <= (tci_mode_decode(bus_req.wdata[CW_MODE_HI:CW_MODE_LO]) != TCI_M0);
          have_reg <= 1'b0;
          armed_reg <= 1'b0;
          pend_reg <= 1'b0;
          trig_reg <= 1'b0;
          null_reg <= 1'b1;
        end
        else
        begin
          if (cfall)
          begin
            trig_reg <= 1'b0;
            pend_reg <= 1'b0;
            case (md)
              TCI_M1, TCI_M5:
              begin
                if (tg && have_reg)
                begin
                  // Retrigger always reloads the full count
                  cnt_reg <= init_reg;
                  armed_reg <= 1'b1;
                  null_reg <= 1'b0;
                  out_reg <= (md == TCI_M5);
                end
                else
                begin
                  cnt_reg <= tci_dec1(cnt_reg, bcd_reg);
                  if (armed_reg && (cnt_reg == 16'h0001))
                  begin
                    armed_reg <= 1'b0;
                    out_reg <= (md == TCI_M1);
                  end
                  else if (md == TCI_M5)
                    out_reg <= 1'b1;
                end
              end
              TCI_M0, TCI_M4:
              begin
                if (pend_reg)
                begin
                  cnt_reg <= init_reg;
                  armed_reg <= 1'b1;
                  null_reg <= 1'b0;
                  out_reg <= (md == TCI_M4);
                end
                else
                begin
                  cnt_reg <= cnt_gate[i] ? tci_dec1(cnt_reg, bcd_reg) : cnt_reg;
                  if (cnt_gate[i] && armed_reg && (cnt_reg == 16'h0001))
                  begin
                    armed_reg <= 1'b0;
                    out_reg <= (md == TCI_M0);
                  end
                  else if (md == TCI_M4)
                    out_reg <= 1'b1;
                end
              end
              TCI_M2:
              begin
                if (!cnt_gate[i])
                  out_reg <= 1'b1;
                else if (pend_reg || (tg && have_reg))
                begin
                  cnt_reg <= init_reg;
                  armed_reg <= 1'b1;
                  null_reg <= 1'b0;
                  out_reg <= 1'b1;
                end
                else if (armed_reg)
                begin
                  if (cnt_reg == 16'h0001)
                  begin
                    // While running, a new count enters here at the period boundary, or above on a gate rise
                    cnt_reg <= init_reg;
                    null_reg <= 1'b0;
                    out_reg <= 1'b1;
                  end
                  else
                  begin
                    cnt_reg <= tci_dec1(cnt_reg, bcd_reg);
                    out_reg <= (cnt_reg != 16'h0002);
                  end
                end
              end
              TCI_M3:
              begin
                if (!cnt_gate[i])
                  out_reg <= 1'b1;
                else if (pend_reg || (tg && have_reg))
                begin
                  cnt_reg <= init_reg;
                  armed_reg <= 1'b1;
                  null_reg <= 1'b0;
                  out_reg <= 1'b1;
                end
                else if (armed_reg)
                begin
                  // Zero stands for the largest count, never terminal at once
                  if ((cnt_reg != 16'h0000) && (cnt_reg <= 16'(amt)))
                  begin
                    out_reg <= !out_reg;
                    cnt_reg <= init_reg;
                    null_reg <= 1'b0;
                  end
                  else
                    cnt_reg <= tci_decn(cnt_reg, amt, bcd_reg);
                end
              end
              default: out_reg <= out_reg;
            endcase
          end
          // Set wins over the clock-fall clear
          if (grise)
            trig_reg <= 1'b1;
          if (commit)
          begin
            have_reg <= 1'b1;
            null_reg <= 1'b1;
            // Mode 1 and 5 wait for a trigger; running mode 2/3 waits for the boundary
            if ((md == TCI_M0) || (md == TCI_M4) || (!armed_reg && ((md == TCI_M2) || (md == TCI_M3))))
              pend_reg <= 1'b1;
          end
        end
      end
    end

    // Hold register, status latch and read byte sequencing
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        hold_reg <= TCI_CNT_RST;
        hold_vld_reg <= 1'b0;
        stat_reg <= 8'h00;
        stat_vld_reg <= 1'b0;
        rphase_reg <= 1'b0;
      end
      else
      begin
        if (rd_hit)
        begin
          if (stat_vld_reg)
            stat_vld_reg <= 1'b0;
          else
          begin
            if (acc_reg == ACC_BOTH)
              rphase_reg <= !rphase_reg;
            if ((acc_reg != ACC_BOTH) || rphase_reg)
              hold_vld_reg <= 1'b0;
          end
        end
        if (cw_prog)
        begin
          rphase_reg <= 1'b0;
          hold_vld_reg <= 1'b0;
        end
        // A second latch before the first is read is ignored
        if (cw_latch && !hold_vld_reg)
        begin
          hold_reg <= cnt_reg;
          hold_vld_reg <= 1'b1;
        end
        if (cw_stat && !stat_vld_reg)
        begin
          stat_reg <= {out_reg, null_reg, acc_reg, mode_reg, bcd_reg};
          stat_vld_reg <= 1'b1;
        end
      end
    end

    // Live reads sample the counter without touching it
    assign src = hold_vld_reg ? hold_reg : cnt_reg;

    always_comb
    begin
      if (stat_vld_reg)
        rd_byte[i] = stat_reg;
      else if ((acc_reg == ACC_HI) || ((acc_reg == ACC_BOTH) && rphase_reg))
        rd_byte[i] = src[15:8];
      else
        rd_byte[i] = src[7:0];
    end
  end

endmodule

// ### test/tci_clk_src.sv
// Counter clock source standing in for the pulse sources at the counter pins
`timescale 1ns/10ps
module tci_clk_src #(
  parameter int HALF = 2
)
(
  input wire logic sys_clk,
  input wire logic reset,
  output logic [2:0] cnt_clk
);
  int half_reg;

  // Free running like an oscillator; halves of HALF cycles so every fall is seen
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      half_reg <= 0;
      cnt_clk <= 3'h7;
    end
    else if (half_reg == HALF - 1)
    begin
      half_reg <= 0;
      cnt_clk <= ~cnt_clk;
    end
    else
      half_reg <= half_reg + 1;
  end
endmodule

// ### test/tci_timer_assertions.sv
// Port-level assertions for the three-channel interval timer
`timescale 1ns/10ps
module tci_timer_assertions
  import tci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire tci_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  input wire logic [2:0] cnt_out
);
  localparam int LOW_MAX = 10;
  logic [2:0] mode0_reg;
  logic [2:0] clk_d_reg;
  logic [2:0] gate_d_reg;
  logic [1:0] act_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Mode of counter 0 as last programmed; latch commands leave it alone
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mode0_reg <= 3'h0;
    else if (bus_req.wr && bus_req.addr == TCI_OFS_CTRL && bus_req.wdata[7:4] > 4'h0 && bus_req.wdata[7:4] < 4'h4)
      mode0_reg <= bus_req.wdata[3:1];
  end

  // Recent causes of an output change; reads are deliberately not among them
  always_ff @(posedge sys_clk)
  begin
    clk_d_reg <= cnt_clk;
    gate_d_reg <= cnt_gate;
    act_reg <= {act_reg[0], (|(clk_d_reg & ~cnt_clk)) || bus_req.wr || (cnt_gate != gate_d_reg)};
  end

  property p_rdata_idle;
    !bus_req.rd |=> bus_rdata == TCI_RD_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_unmapped;
    bus_req.rd && (bus_req.addr < TCI_OFS_CNT0 || bus_req.addr > TCI_OFS_CNT2) |=> bus_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unreadable place gave data");
  property p_out_cause;
    act_reg == 2'h0 |-> $stable(cnt_out);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved without cause");
  // Gate low acts at the next counter clock fall, up to one period later
  property p_m23_gate;
    mode0_reg[1] && !cnt_gate[0] [*6] |-> cnt_out[0];
  endproperty
  a_m23_gate: assert property (p_m23_gate) else $error("low gate did not hold output high");
  property p_short_low;
    mode0_reg inside {3'h2, 3'h4, 3'h5, 3'h6} && $fell(cnt_out[0]) |-> ##[1:LOW_MAX] cnt_out[0];
  endproperty
  a_short_low: assert property (p_short_low) else $error("strobe pulse too long");
  property p_m1_idle;
    mode0_reg == 3'h1 && (cnt_out[0] && !cnt_gate[0]) [*8] |=> cnt_out[0];
  endproperty
  a_m1_idle: assert property (p_m1_idle) else $error("one-shot fired without trigger");
  property p_m4_gate;
    mode0_reg == 3'h4 && !cnt_gate[0] [*8] |-> cnt_out[0];
  endproperty
  a_m4_gate: assert property (p_m4_gate) else $error("strobe while gate low");
  property p_reset_out;
    $fell(reset) |-> cnt_out == 3'h7 && bus_rdata == TCI_RD_IDLE;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
endmodule

bind tci_timer tci_timer_assertions i_chk (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));

// ### test/test_three_channel_interval_timer.sv
// Self-checking bench for the three-channel interval timer
`timescale 1ns/10ps
module test_three_channel_interval_timer;
  import tci_pkg::*;
  localparam int P = 4;
  logic sys_clk;
  logic reset;
  tci_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic [2:0] cnt_clk;
  logic [2:0] cnt_gate;
  logic [2:0] cnt_out;
  logic rd_d;
  logic [7:0] exp_q[$];
  int mismatches;
  int total_checks;
  int cycles;
  int lo;
  int hi;
  time t0;
  logic [15:0] cnt_val;

  tci_timer i_dut (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));
  tci_clk_src #(.HALF(P / 2)) i_src (.sys_clk(sys_clk), .reset(reset), .cnt_clk(cnt_clk));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One-cycle strobes; release waits a full edge so tasks can follow back to back
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
  endtask

  task automatic prog(input logic [1:0] c, input logic [1:0] acc, input logic [2:0] m);
    bus_wr(TCI_OFS_CTRL, {c, acc, m, 1'b0});
  endtask

  task automatic load(input logic [1:0] c, input logic [15:0] v);
    bus_wr(TCI_OFS_CNT0 + 8'(c), v[7:0]);
    bus_wr(TCI_OFS_CNT0 + 8'(c), v[15:8]);
  endtask

  // Length in system clocks of the next whole run of one output level, or of the rest of the run already under way
  task automatic run_len(input int ch, input logic lvl, output int len);
    len = 0;
    while (cnt_out[ch] !== lvl)
      @(posedge sys_clk);
    while (cnt_out[ch] === lvl)
    begin
      @(posedge sys_clk);
      len++;
    end
  endtask

  // Read data stand only in the cycle after the strobe, so compare there
  always @(posedge sys_clk)
  begin
    rd_d <= bus_req.rd;
    if (rd_d === 1'b1)
      check({8'h00, bus_rdata}, {8'h00, exp_q.pop_front()});
  end

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    reset = 1'b1;
    bus_req = '0;
    cnt_gate = 3'h0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(32'h1432));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    bus_rd(8'($urandom % 24), 8'h00);
    bus_rd(TCI_OFS_CTRL, 8'h00);
    // Status of each counter in each mode, before any count is written
    for (int m = 0; m <= 5; m++)
      for (int c = 0; c < 3; c++)
      begin
        prog(2'(c), ACC_BOTH, 3'(m));
        bus_wr(TCI_OFS_CTRL, 8'he0 | 8'(2 << c));
        bus_rd(TCI_OFS_CNT0 + 8'(c), {m != 0, 1'b1, ACC_BOTH, 3'(m), 1'b0});
      end
    // Gate low holds a loaded strobe count still; both latch forms return it
    cnt_val = 16'($urandom_range(65520, 256));
    prog(2'h0, ACC_BOTH, 3'h4);
    load(2'h0, cnt_val);
    repeat (4 * P) @(posedge sys_clk);
    bus_wr(TCI_OFS_CTRL, 8'h00);
    bus_rd(TCI_OFS_CNT0, cnt_val[7:0]);
    bus_rd(TCI_OFS_CNT0, cnt_val[15:8]);
    bus_wr(TCI_OFS_CTRL, 8'hd2);
    bus_rd(TCI_OFS_CNT0, cnt_val[7:0]);
    bus_rd(TCI_OFS_CNT0, cnt_val[15:8]);
    load(2'h0, 16'($urandom_range(8, 2)));
    cnt_gate <= 3'h7;
    run_len(0, 1'b0, lo);
    check(16'(lo), 16'(P));
    // Rate generator of three, reloaded with five during the high part
    prog(2'h1, ACC_LO, 3'h2);
    bus_wr(TCI_OFS_CNT1, 8'h03);
    run_len(1, 1'b0, lo);
    check(16'(lo), 16'(P));
    t0 = $time;
    bus_wr(TCI_OFS_CNT1, 8'h05);
    run_len(1, 1'b0, lo);
    check(16'(($time - t0) / 50), 16'(3 * P));
    run_len(1, 1'b1, hi);
    check(16'(hi), 16'(4 * P));
    // Square wave with an odd and an even count
    for (int n = 5; n <= 6; n++)
    begin
      prog(2'h2, ACC_LO, 3'h3);
      bus_wr(TCI_OFS_CNT2, 8'(n));
      run_len(2, 1'b0, lo);
      run_len(2, 1'b1, hi);
      check(16'(lo), 16'((n / 2) * P));
      check(16'(hi), 16'(((n + 1) / 2) * P));
    end
    // Gate-triggered one-shot of three, then strobe of two
    for (int m = 1; m <= 5; m += 4)
    begin
      prog(2'h0, ACC_LO, 3'(m));
      bus_wr(TCI_OFS_CNT0, 8'(m == 1 ? 3 : 2));
      cnt_gate[0] <= 1'b0;
      @(posedge sys_clk);
      cnt_gate[0] <= 1'b1;
      run_len(0, 1'b0, lo);
      check(16'(lo), 16'((m == 1 ? 3 : 1) * P));
    end
    // Count of six written mid-pulse; the running pulse keeps three, the next trigger takes six
    prog(2'h0, ACC_LO, 3'h1);
    bus_wr(TCI_OFS_CNT0, 8'h03);
    for (int k = 3; k <= 6; k += 3)
    begin
      cnt_gate[0] <= 1'b0;
      @(posedge sys_clk);
      cnt_gate[0] <= 1'b1;
      while (cnt_out[0] !== 1'b0)
        @(posedge sys_clk);
      t0 = $time;
      bus_wr(TCI_OFS_CNT0, 8'h06);
      run_len(0, 1'b0, lo);
      check(16'(($time - t0) / 50), 16'(k * P));
    end
    repeat (4) @(posedge sys_clk);
    summarize();
  end
endmodule
